// ### core/touch_event_fifo_i2c_target.sv
// touch event buffer with read-only i2c target and power sequencer
// assumes scl/sda come from pins (synchronised here), engine on core_clk_i
//
// Behaviour
// - stay active until counts-until-sleep quiet periods
// - free run rescans, else idle rest of period
// - sleep: scan wakeup inputs each sleep period
// - proximity selected: scan only proximity in sleep
// - packets buffered; interrupt while any waiting
// - interrupt active low, push-pull output
// - interrupt released once all packets transferred
// - never sleep while packets remain buffered
// - pop only after last byte; partial resent
// - empty buffer read returns three 0xff bytes
// - padding group completes before real packet
// - early stop keeps packet, restarts at byte0
// - 22 packets; overflow drops oldest first, stalls instead while i2c busy
// - timeout while interrupt asserted flushes buffer
// - bytes shifted out msb first
// - four-bit sequence counter, wraps 15 to 0
// - low nibble event type: 0,1,2
// - touch/release first description byte is sensor
// - slider position sixteen bits, msb first
// - slider release reports position 0xffff
// - ack address only while interrupt low
`timescale 1ns/10ps

module stage_fifo #(
	parameter int W = 25,
	parameter int D = 8
) (
	input  wire logic         core_clk_i,
	input  wire logic         reset_i,
	// fill side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// drain side
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	logic [AW:0]   cnt_next;
	logic          wr_en;
	logic          rd_en;

	assign wr_en = in_valid_i && in_ready_o;
	assign rd_en = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_reg];
	assign cnt_next = cnt_reg + (AW+1)'(wr_en) - (AW+1)'(rd_en);

	always_ff @(posedge core_clk_i) begin
		if (wr_en) begin
			mem[wr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_reg      <= '0;
			rd_reg      <= '0;
			cnt_reg     <= '0;
			in_ready_o  <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			if (wr_en)
				wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
			if (rd_en)
				rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg     <= cnt_next;
			// registered flags from cnt_next: full/empty change on the same edge as the count
			in_ready_o  <= cnt_next != (AW+1)'(D);
			out_valid_o <= cnt_next != '0;
		end
	end
endmodule // stage_fifo

module touch_event_fifo_i2c_target
	import touch_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	// events from the qualification engine
	input  wire logic        evt_valid_i,
	input  wire event_t      evt_i,
	output logic             evt_ready_o,
	// power sequencing configuration
	input  wire logic        free_run_i,
	input  wire logic        prox_sel_i,
	input  wire logic [7:0]  counts_until_sleep_i,
	input  wire logic [15:0] active_period_ms_i,
	input  wire logic [15:0] sleep_period_ms_i,
	// engine status
	input  wire logic        touch_active_i,
	input  wire logic        scan_done_i,
	input  wire logic        candidate_i,
	input  wire logic        prox_detect_i,
	// engine control
	output logic             scan_run_o,
	output logic             low_power_o,
	output logic             sleep_mode_o,
	output logic             wake_scan_o,
	output logic             prox_scan_o,
	// i2c target and interrupt
	input  wire logic [6:0]  target_addr_i,
	input  wire logic        timeout_en_i,
	input  wire logic [15:0] timeout_ms_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	output logic             irq_n_o
);
	// ms tick divider
	logic [31:0] div_reg;
	logic        ms_tick;
	assign ms_tick = div_reg == 32'(TICK_CYCLES - 1);

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			div_reg <= '0;
		else
			div_reg <= ms_tick ? '0 : div_reg + 32'h1;
	end

	// staging fifo in the event path
	event_t  stg_data;
	logic    stg_valid;
	logic    stg_ready;

	stage_fifo #(.W($bits(event_t)), .D(STG_DEPTH)) u_stage (
		.core_clk_i  (core_clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (evt_valid_i),
		.in_data_i   (evt_i),
		.in_ready_o  (evt_ready_o),
		.out_valid_o (stg_valid),
		.out_data_o  (stg_data),
		.out_ready_i (stg_ready)
	);

	// packet store
	packet_t    store [DEPTH];
	logic [4:0] rd_reg;
	logic [4:0] wr_reg;
	logic [4:0] cnt_reg;
	logic [3:0] seq_reg;
	logic       full;
	logic       push;
	logic       pop;
	logic       drop;
	logic       flush;
	logic       i2c_busy;
	packet_t    pkt;
	packet_t    head;

	assign full = cnt_reg == DEPTH_C;
	// stall the drain rather than drop the head the host is reading
	assign stg_ready = !flush && !(full && i2c_busy);
	assign push = stg_valid && stg_ready;
	assign drop = push && full && !pop;
	assign head = store[rd_reg];

	always_comb begin
		pkt.seq  = seq_reg;
		pkt.kind = stg_data.kind;
		if (stg_data.kind == EVT_SLIDER) begin
			if (stg_data.slider_up) begin
				pkt.desc_hi = SLIDER_UP[15:8];
				pkt.desc_lo = SLIDER_UP[7:0];
			end else begin
				pkt.desc_hi = stg_data.pos[15:8];
				pkt.desc_lo = stg_data.pos[7:0];
			end
		end else begin
			pkt.desc_hi = {4'h0, stg_data.sensor};
			pkt.desc_lo = UNUSED_BYTE;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (push)
			store[wr_reg] <= pkt;
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_reg  <= '0;
			wr_reg  <= '0;
			cnt_reg <= '0;
			seq_reg <= '0;
		end else if (flush) begin
			rd_reg  <= wr_reg;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg  <= (wr_reg == LAST_SLOT) ? '0 : wr_reg + 5'h1;
				seq_reg <= seq_reg + 4'h1;
			end
			if (pop || drop)
				rd_reg <= (rd_reg == LAST_SLOT) ? '0 : rd_reg + 5'h1;
			cnt_reg <= cnt_reg + 5'(push && !drop) - 5'(pop);
		end
	end

	// interrupt, push-pull, active low
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			irq_n_o <= 1'b1;
		else
			irq_n_o <= cnt_reg == '0;
	end

	// flush timeout
	logic [15:0] to_reg;
	assign flush = timeout_en_i && !irq_n_o && ms_tick &&
		(to_reg + 16'h1 >= timeout_ms_i);

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			to_reg <= '0;
		else if (irq_n_o || flush)
			to_reg <= '0;
		else if (ms_tick)
			to_reg <= to_reg + 16'h1;
	end

	// power sequencer
	pwr_state_t  pw_reg;
	pwr_state_t  pw_next;
	logic [15:0] per_reg;
	logic [7:0]  idle_reg;
	logic        per_end;
	logic        active;
	logic        go_sleep;
	logic        wake;

	assign active  = pw_reg == PW_ACT_SCAN || pw_reg == PW_ACT_IDLE;
	assign per_end = ms_tick && (per_reg + 16'h1 >= (active ?
		active_period_ms_i : sleep_period_ms_i));
	assign go_sleep = per_end && !touch_active_i && !stg_valid &&
		cnt_reg == '0 &&
		idle_reg + 8'h1 >= counts_until_sleep_i;
	assign wake = prox_sel_i ? prox_detect_i : candidate_i;

	always_comb begin
		pw_next = pw_reg;
		case (pw_reg)
			PW_ACT_SCAN: begin
				if (go_sleep)
					pw_next = PW_SLP_WAIT;
				else if (scan_done_i && !free_run_i)
					pw_next = PW_ACT_IDLE;
			end
			PW_ACT_IDLE: begin
				if (go_sleep)
					pw_next = PW_SLP_WAIT;
				else if (per_end)
					pw_next = PW_ACT_SCAN;
			end
			PW_SLP_WAIT: begin
				if (per_end)
					pw_next = PW_SLP_SCAN;
			end
			PW_SLP_SCAN: begin
				if (scan_done_i)
					pw_next = wake ? PW_ACT_SCAN : PW_SLP_WAIT;
			end
			default: pw_next = PW_ACT_SCAN;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pw_reg       <= PW_ACT_SCAN;
			per_reg      <= '0;
			idle_reg     <= '0;
			scan_run_o   <= 1'b0;
			low_power_o  <= 1'b0;
			sleep_mode_o <= 1'b0;
			wake_scan_o  <= 1'b0;
			prox_scan_o  <= 1'b0;
		end else begin
			pw_reg <= pw_next;
			if (per_end || active != (pw_next == PW_ACT_SCAN ||
				pw_next == PW_ACT_IDLE))
				per_reg <= '0;
			else if (ms_tick)
				per_reg <= per_reg + 16'h1;
			if (!active || touch_active_i)
				idle_reg <= '0;
			else if (per_end && idle_reg != 8'hff)
				idle_reg <= idle_reg + 8'h1;
			scan_run_o   <= pw_next == PW_ACT_SCAN || pw_next == PW_SLP_SCAN;
			low_power_o  <= pw_next == PW_ACT_IDLE || pw_next == PW_SLP_WAIT;
			sleep_mode_o <= pw_next == PW_SLP_WAIT || pw_next == PW_SLP_SCAN;
			wake_scan_o  <= pw_next == PW_SLP_SCAN && !prox_sel_i;
			prox_scan_o  <= pw_next == PW_SLP_SCAN && prox_sel_i;
		end
	end

	// pin synchronisers; first stage read only by the second
	logic [1:0] scl_ff;
	logic [1:0] sda_ff;
	logic       scl_q;
	logic       sda_q;

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			scl_ff <= 2'h3;
			sda_ff <= 2'h3;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
		end else begin
			scl_ff <= {scl_ff[0], scl_i};
			sda_ff <= {sda_ff[0], sda_i};
			scl_q  <= scl_ff[1];
			sda_q  <= sda_ff[1];
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise  = scl_ff[1] && !scl_q;
	assign scl_fall  = !scl_ff[1] && scl_q;
	assign start_det = scl_ff[1] && scl_q && sda_q && !sda_ff[1];
	assign stop_det  = scl_ff[1] && scl_q && !sda_q && sda_ff[1];

	// i2c target, read only
	i2c_state_t i2_reg;
	logic [2:0] bit_reg;
	logic [1:0] idx_reg;
	logic       pad_reg;
	logic       mack_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_byte;
	logic       pad_now;
	logic [7:0] addr_byte;

	assign i2c_busy  = i2_reg != I2_IDLE;
	assign addr_byte = {sh_reg[6:0], sda_ff[1]};
	assign pad_now   = (idx_reg == 2'h0) ? cnt_reg == '0 : pad_reg;
	assign pop = i2_reg == I2_MACK && scl_rise && idx_reg == LAST_BYTE &&
		!pad_reg && cnt_reg != '0;

	always_comb begin
		case (idx_reg)
			2'h0:    tx_byte = {head.seq, head.kind};
			2'h1:    tx_byte = head.desc_hi;
			default: tx_byte = head.desc_lo;
		endcase
		if (pad_now)
			tx_byte = PAD_BYTE;
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			i2_reg   <= I2_IDLE;
			bit_reg  <= '0;
			idx_reg  <= '0;
			pad_reg  <= 1'b0;
			mack_reg <= 1'b0;
			sh_reg   <= '0;
			sda_oe_o <= 1'b0;
			sda_o    <= 1'b0;
		end else if (stop_det || start_det) begin
			// a cut-short packet is resent from its first byte
			idx_reg  <= '0;
			bit_reg  <= '0;
			mack_reg <= 1'b0;
			sda_oe_o <= 1'b0;
			i2_reg   <= start_det ? I2_ADDR : I2_IDLE;
		end else begin
			case (i2_reg)
				I2_ADDR: begin
					if (scl_rise) begin
						sh_reg  <= addr_byte;
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == BIT_LAST)
							i2_reg <= (addr_byte[7:1] == target_addr_i &&
								addr_byte[0] && !irq_n_o) ?
								I2_AACK : I2_IDLE;
					end
				end
				I2_AACK: begin
					if (scl_fall && !sda_oe_o) begin
						sda_oe_o <= 1'b1;
					end else if (scl_fall) begin
						i2_reg <= I2_LOAD;
						sda_oe_o <= 1'b0;
					end
				end
				I2_LOAD: begin
					if (idx_reg == 2'h0)
						pad_reg <= pad_now;
					sh_reg   <= {tx_byte[6:0], 1'b0};
					sda_oe_o <= !tx_byte[7];
					bit_reg  <= '0;
					i2_reg   <= I2_TX;
				end
				I2_TX: begin
					if (scl_fall) begin
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == BIT_LAST) begin
							sda_oe_o <= 1'b0;
							i2_reg   <= I2_MACK;
						end else begin
							sda_oe_o <= !sh_reg[7];
							sh_reg   <= {sh_reg[6:0], 1'b0};
						end
					end
				end
				I2_MACK: begin
					if (scl_rise) begin
						idx_reg <= (idx_reg == LAST_BYTE) ? 2'h0 :
							idx_reg + 2'h1;
						if (sda_ff[1])
							i2_reg <= I2_IDLE;
						else
							mack_reg <= 1'b1;
					end else if (scl_fall && mack_reg) begin
						// next byte starts right here; no ack slot of ours
						mack_reg <= 1'b0;
						i2_reg   <= I2_LOAD;
					end
				end
				default: i2_reg <= I2_IDLE;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_last_ack;
		i2_reg == I2_MACK && scl_rise && idx_reg == LAST_BYTE;
	endsequence

	property p_irq_on;
		cnt_reg != '0 |=> !irq_n_o;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq not low");

	property p_irq_off;
		cnt_reg == '0 |=> irq_n_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq stuck");

	property p_depth;
		cnt_reg <= DEPTH_C;
	endproperty
	a_depth: assert property (p_depth) else $error("store overrun");

	property p_pop_last;
		cnt_reg < $past(cnt_reg) |-> $past(flush) || $past(pop);
	endproperty
	a_pop_last: assert property (p_pop_last) else $error("early pop");

	property p_pop_cause;
		s_last_ack ##0 (!pad_reg && cnt_reg != '0 && !flush) |=>
			rd_reg != $past(rd_reg);
	endproperty
	a_pop_cause: assert property (p_pop_cause) else $error("bad pop");

	property p_partial_keep;
		i2_reg == I2_MACK && scl_rise && idx_reg != LAST_BYTE && !flush
			|=> rd_reg == $past(rd_reg);
	endproperty
	a_partial_keep: assert property (p_partial_keep) else $error("lost");

	property p_stop_rewind;
		stop_det |=> idx_reg == 2'h0 && i2_reg == I2_IDLE;
	endproperty
	a_stop_rewind: assert property (p_stop_rewind) else $error("no rewind");

	property p_pad_ff;
		i2_reg == I2_LOAD && pad_now |=> !sda_oe_o;
	endproperty
	a_pad_ff: assert property (p_pad_ff) else $error("pad not ff");

	property p_pad_hold;
		$changed(pad_reg) |-> $past(idx_reg) == 2'h0;
	endproperty
	a_pad_hold: assert property (p_pad_hold) else $error("pad cut");

	property p_nack_high;
		i2_reg == I2_ADDR && scl_rise && bit_reg == BIT_LAST && irq_n_o
			&& !stop_det && !start_det |=> i2_reg == I2_IDLE ##1 !sda_oe_o;
	endproperty
	a_nack_high: assert property (p_nack_high) else $error("acked");

	property p_seq;
		push && !flush |=> seq_reg == $past(seq_reg) + 4'h1;
	endproperty
	a_seq: assert property (p_seq) else $error("seq skip");

	property p_flush;
		flush |=> cnt_reg == '0 ##1 irq_n_o;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush");

	property p_awake;
		active && cnt_reg != '0 |=> pw_reg == PW_ACT_SCAN ||
			pw_reg == PW_ACT_IDLE;
	endproperty
	a_awake: assert property (p_awake) else $error("slept");
endmodule // touch_event_fifo_i2c_target

// ### core/touch_pkg.sv
// touch event buffer: shared constants, packet layout and state types
// assumes a single 200 MHz core clock; the engine sits on that clock
package touch_pkg;
	localparam int CLK_HZ     = 200_000_000;
	localparam int TICK_MS    = 1;
	// cycles per millisecond tick of the period and timeout timers
	localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
	localparam int DEPTH      = 22;
	localparam int STG_DEPTH  = 8;
	localparam logic [4:0] DEPTH_C = 5'h16;
	localparam logic [4:0] LAST_SLOT = 5'h15;
	localparam logic [3:0] EVT_TOUCH   = 4'h0;
	localparam logic [3:0] EVT_RELEASE = 4'h1;
	localparam logic [3:0] EVT_SLIDER  = 4'h2;
	localparam logic [7:0] PAD_BYTE    = 8'hff;
	localparam logic [7:0] UNUSED_BYTE = 8'h00;
	localparam logic [15:0] SLIDER_UP  = 16'hffff;
	localparam logic [1:0] LAST_BYTE   = 2'h2;
	localparam logic [2:0] BIT_LAST    = 3'h7;

	typedef struct packed {
		logic [3:0]  kind;
		logic [3:0]  sensor;
		logic        slider_up;
		logic [15:0] pos;
	} event_t;

	typedef struct packed {
		logic [3:0] seq;
		logic [3:0] kind;
		logic [7:0] desc_hi;
		logic [7:0] desc_lo;
	} packet_t;

	typedef enum logic [1:0] {
		PW_ACT_SCAN, PW_ACT_IDLE, PW_SLP_WAIT, PW_SLP_SCAN
	} pwr_state_t;

	typedef enum logic [2:0] {
		I2_IDLE, I2_ADDR, I2_AACK, I2_TX, I2_MACK, I2_LOAD
	} i2c_state_t;
endpackage

// ### verification/i2c_host_model.sv
// i2c controller model for the event buffer host side
// assumes the bench resolves the open-drain sda wire with a pull-up
`timescale 1ns/10ps

module i2c_host_model #(
	parameter int HALF_NS = 32
) (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	// scl stands high between frames; data moves only while scl is low
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	// one bit: entered and left with scl low; drive 1 releases the line
	task automatic clk_bit(input logic drive, output logic seen);
		#8 sda_pull_o = !drive;
		#(HALF_NS - 8) scl_o = 1'b1;
		#(HALF_NS / 2) seen = sda_i;
		#(HALF_NS / 2) scl_o = 1'b0;
	endtask

	task automatic start_c();
		#HALF_NS sda_pull_o = 1'b1;
		#HALF_NS scl_o = 1'b0;
	endtask

	task automatic stop_c();
		#8 sda_pull_o = 1'b1;
		#(HALF_NS - 8) scl_o = 1'b1;
		#HALF_NS sda_pull_o = 1'b0;
		#HALF_NS;
	endtask

	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], seen);
		clk_bit(1'b1, seen);
		ack = !seen;
	endtask

	// msb arrives first; a nack on the last byte ends the read
	task automatic read_byte(input logic ack, output logic [7:0] b);
		logic seen;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, b[i]);
		clk_bit(!ack, seen);
	endtask
endmodule // i2c_host_model

// ### verification/tb_top.sv
// bench for the touch event buffer: event driver, host reads, mode checks
// assumes the package, design and host model are compiled before it
`timescale 1ns/10ps

module tb_top;
	import touch_pkg::*;
	localparam logic [6:0] ADDR = 7'h2a;
	logic       core_clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       evt_valid_i = 1'b0;
	event_t     evt_i = '0;
	logic       free_run_i = 1'b0;
	logic       prox_sel_i = 1'b0;
	logic       touch_active_i = 1'b1;
	logic       scan_done_i = 1'b0;
	logic       candidate_i = 1'b0;
	logic       prox_detect_i = 1'b0;
	logic       timeout_en_i = 1'b0;
	logic       scl;
	logic       pull;
	logic       sda_line;
	logic       evt_ready_o;
	logic       scan_run_o;
	logic       low_power_o;
	logic       sleep_mode_o;
	logic       wake_scan_o;
	logic       prox_scan_o;
	logic       sda_o;
	logic       sda_oe_o;
	logic       irq_n_o;
	logic       ack;
	logic [7:0] got [0:65];
	int         mismatches = 0;
	int         samples_checked = 0;

	always #2.5 core_clk_i = ~core_clk_i;
	assign sda_line = pull ? 1'b0 : (sda_oe_o ? sda_o : 1'b1);

	i2c_host_model host (.sda_i(sda_line), .scl_o(scl), .sda_pull_o(pull));

	// short ms tick keeps period waits to 20 cycles and the 6 ms timeout to at most 120 cycles
	touch_event_fifo_i2c_target #(.TICK_CYCLES(20)) DUT (
		.core_clk_i(core_clk_i), .reset_i(reset_i),
		.evt_valid_i(evt_valid_i), .evt_i(evt_i),
		.evt_ready_o(evt_ready_o), .free_run_i(free_run_i),
		.prox_sel_i(prox_sel_i), .counts_until_sleep_i(8'h02),
		.active_period_ms_i(16'h0001), .sleep_period_ms_i(16'h0001),
		.touch_active_i(touch_active_i), .scan_done_i(scan_done_i),
		.candidate_i(candidate_i), .prox_detect_i(prox_detect_i),
		.scan_run_o(scan_run_o), .low_power_o(low_power_o),
		.sleep_mode_o(sleep_mode_o), .wake_scan_o(wake_scan_o),
		.prox_scan_o(prox_scan_o), .target_addr_i(ADDR),
		.timeout_en_i(timeout_en_i), .timeout_ms_i(16'h0006),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .irq_n_o(irq_n_o));

	task automatic chk(input string what, input logic [15:0] exp,
			input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			mismatches++;
		end
	endtask

	task automatic send(input logic [3:0] k, input logic [3:0] s,
			input logic up, input logic [15:0] p);
		@(negedge core_clk_i);
		evt_valid_i = 1'b1;
		evt_i = {k, s, up, p};
		for (int i = 0; i < 200; i++) begin
			@(posedge core_clk_i);
			if (evt_ready_o === 1'b1)
				break;
		end
		@(negedge core_clk_i);
		evt_valid_i = 1'b0;
	endtask

	// last byte is nacked so the target lets go before the stop
	task automatic rd(input int n);
		host.start_c();
		host.write_byte({ADDR, 1'b1}, ack);
		for (int i = 0; i < n && ack === 1'b1; i++)
			host.read_byte(i < n - 1, got[i]);
		host.stop_c();
	endtask

	task automatic wait_for(input int which, input logic v, input int lim);
		logic s;
		for (int i = 0; i < lim; i++) begin
			@(negedge core_clk_i);
			case (which)
				0:       s = irq_n_o;
				1:       s = sleep_mode_o;
				2:       s = wake_scan_o;
				default: s = prox_scan_o;
			endcase
			if (s === v)
				break;
		end
	endtask

	task automatic pulse_scan();
		@(negedge core_clk_i);
		scan_done_i = 1'b1;
		@(negedge core_clk_i);
		scan_done_i = 1'b0;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#300000;
		mismatches++;
		close_out();
	end

	initial begin
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
		reset_i = 1'b0;
		repeat (4) @(negedge core_clk_i);
		chk("irq_n idle", 1'b1, irq_n_o);
		chk("evt ready", 1'b1, evt_ready_o);
		rd(3);
		chk("ack irq high", 1'b0, ack);
		pulse_scan();
		repeat (2) @(negedge core_clk_i);
		chk("low_power", 1'b1, low_power_o);
		chk("scan idle", 1'b0, scan_run_o);
		$display("test basics done");

		send(EVT_TOUCH, 4'hb, 1'b0, 16'h0000);
		wait_for(0, 1'b0, 40);
		chk("irq_n pending", 1'b0, irq_n_o);
		rd(1);
		chk("ack irq low", 1'b1, ack);
		chk("irq_n partial", 1'b0, irq_n_o);
		rd(3);
		chk("touch b0", {4'h0, EVT_TOUCH}, got[0]);
		chk("touch b1", 8'h0b, got[1]);
		chk("touch b2", UNUSED_BYTE, got[2]);
		wait_for(0, 1'b1, 20);
		chk("irq_n drained", 1'b1, irq_n_o);
		$display("test touch done");

		send(EVT_RELEASE, 4'h5, 1'b0, 16'h0000);
		send(EVT_SLIDER, 4'h0, 1'b0, 16'h1234);
		send(EVT_SLIDER, 4'h0, 1'b1, 16'h0000);
		repeat (10) @(negedge core_clk_i);
		rd(9);
		chk("rel b0", {4'h1, EVT_RELEASE}, got[0]);
		chk("rel b1", 8'h05, got[1]);
		chk("sld b0", {4'h2, EVT_SLIDER}, got[3]);
		chk("slider pos", 16'h1234, {got[4], got[5]});
		chk("sld up b0", {4'h3, EVT_SLIDER}, got[6]);
		chk("slider up", SLIDER_UP, {got[7], got[8]});
		$display("test slider done");

		// 24 events into 22 slots: seq 4 and 5 are the ones dropped
		for (int i = 0; i < 24; i++)
			send(EVT_TOUCH, 4'(i % 12), 1'b0, 16'h0000);
		repeat (20) @(negedge core_clk_i);
		rd(66);
		for (int j = 0; j < 22; j++) begin
			chk("ovf seq", 16'((6 + j) % 16), got[3 * j][7:4]);
			chk("ovf sensor", 16'((j + 2) % 12), got[3 * j + 1]);
		end
		$display("test overflow done");

		@(negedge core_clk_i);
		touch_active_i = 1'b0;
		timeout_en_i = 1'b1;
		send(EVT_TOUCH, 4'h0, 1'b0, 16'h0000);
		wait_for(0, 1'b0, 40);
		repeat (80) @(negedge core_clk_i);
		chk("awake while buffered", 1'b0, sleep_mode_o);
		wait_for(0, 1'b1, 100);
		chk("irq_n flushed", 1'b1, irq_n_o);
		wait_for(1, 1'b1, 300);
		chk("sleep entered", 1'b1, sleep_mode_o);
		$display("test timeout done");

		wait_for(2, 1'b1, 100);
		chk("wakeup scan", 1'b1, wake_scan_o);
		pulse_scan();
		repeat (2) @(negedge core_clk_i);
		chk("no candidate", 1'b1, sleep_mode_o);
		prox_sel_i = 1'b1;
		wait_for(3, 1'b1, 100);
		chk("prox scan", 1'b1, prox_scan_o);
		chk("prox only", 1'b0, wake_scan_o);
		candidate_i = 1'b1;
		pulse_scan();
		repeat (2) @(negedge core_clk_i);
		chk("candidate ignored", 1'b1, sleep_mode_o);
		wait_for(3, 1'b1, 100);
		prox_detect_i = 1'b1;
		pulse_scan();
		repeat (3) @(negedge core_clk_i);
		chk("prox woken", 1'b0, sleep_mode_o);
		// free run keeps the engine scanning after each scan
		free_run_i = 1'b1;
		pulse_scan();
		repeat (2) @(negedge core_clk_i);
		chk("free run", 1'b0, low_power_o);
		chk("free run scan", 1'b1, scan_run_o);
		free_run_i = 1'b0;
		prox_sel_i = 1'b0;
		prox_detect_i = 1'b0;
		wait_for(1, 1'b1, 300);
		wait_for(2, 1'b1, 100);
		pulse_scan();
		repeat (3) @(negedge core_clk_i);
		chk("candidate woken", 1'b0, sleep_mode_o);
		$display("test wake done");
		close_out();
	end
endmodule // tb_top
